// ### seq_ctrl_defs.svh
`ifndef SEQ_CTRL_DEFS_SVH
`define SEQ_CTRL_DEFS_SVH

// Register byte offsets
`define REG_CMD 8'h00
`define REG_SETV 8'h04
`define REG_SETI 8'h08
`define REG_SETP 8'h0c
`define REG_SLOT 8'h10
`define REG_MODE 8'h14
`define REG_STEP 8'h18
`define REG_FIRST 8'h1c
`define REG_LAST 8'h20
`define REG_LOOPS 8'h24
`define REG_ISTAT 8'h28
`define REG_IMASK 8'h2c

// Command word fields
`define CMD_VAL_LSB 0
`define CMD_VAL_MSB 15
`define CMD_OP_LSB 16
`define CMD_OP_MSB 19

// Status bit positions
`define IRQ_ERR 0
`define IRQ_DONE 1
`define IRQ_PASS 2

// Value limits
`define SLOT_MAX 16'h0003
`define MODE_MAX 16'h0002
`define STEP_MAX 16'h0063
`define LOOP_MAX 16'h03e7
`define STEP_LAST 7'h63

// Reset values
`define SETV_RST 16'h0000
`define SETI_RST 16'h0000
`define SETP_RST 16'h0000
`define IMASK_RST 3'h0

// Timing: clock rate and time spent on each step while running
`define CLK_MHZ 10
`define STEP_TIME_US 1000

`endif

// ### seq_ctrl_pkg.sv
package seq_ctrl_pkg;

  typedef enum logic [3:0] {
    CMD_RECALL = 4'b0000,
    CMD_SAVE = 4'b0001,
    CMD_MODE = 4'b0010,
    CMD_JUMP = 4'b0011,
    CMD_FIRST = 4'b0100,
    CMD_LAST = 4'b0101,
    CMD_LOOPS = 4'b0110
  } cmd_t;

  typedef enum logic [1:0] {
    SEQ_STOP = 2'b00,
    SEQ_PAUSE = 2'b01,
    SEQ_RUN = 2'b10
  } seq_mode_t;

endpackage

// ### slot_store.sv
`timescale 1ns/100ps
module slot_store (
  input wire logic clk,
  input wire logic wrEn,
  input wire logic [1:0] wrAddr,
  input wire logic [47:0] wrData,
  input wire logic [1:0] rdAddr,
  output logic [47:0] rdData
);

  logic [47:0] mem [0:3];

  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  // Registered read; caller waits one cycle
  always_ff @(posedge clk) begin
    rdData <= mem[rdAddr];
  end

endmodule

// ### setting_slot_and_sequence_control.sv
// Functional notes
// - Recall 0 cancels slot; 1 to 3 load stored voltage, current, power
// - Slot query returns active slot, 0 meaning none
// - Recall, save or jump while running flags error, changes nothing
// - Save copies present voltage, current, power into the slot
// - Save accepts slots 1 to 3 only; no query form
// - Mode value 0 stops, 1 pauses, 2 runs
// - Mode query returns present mode, 2 while running
// - Jump accepts steps 0 to 99, only while paused
// - Jump query returns current step and completed loops
// - Start step 0 to 99 held and readable
// - End step 0 to 99 held and readable
// - Loop count 0 to 999 held and readable
// - Loop count 0 repeats endlessly until stopped
//
// The address map and register access over Wishbone were left to the implementer.
`timescale 1ns/100ps
`include "seq_ctrl_defs.svh"
module setting_slot_and_sequence_control #(
  parameter int STEP_CYCLES = `STEP_TIME_US * `CLK_MHZ
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic irq,
  output logic [15:0] outVolt,
  output logic [15:0] outCurr,
  output logic [15:0] outPow,
  output logic [6:0] seqStep,
  output seq_ctrl_pkg::seq_mode_t seqMode
);
  import seq_ctrl_pkg::*;

  logic rstMeta_r;
  logic rstSync_r;
  logic ack_r;
  logic [31:0] dat_r;
  logic [31:0] cmdWord_r;
  logic [15:0] setV_r;
  logic [15:0] setI_r;
  logic [15:0] setP_r;
  logic [1:0] activeSlot_r;
  logic loadPend_r;
  seq_mode_t mode_r;
  logic [6:0] step_r;
  logic [9:0] loopsDone_r;
  logic [6:0] first_r;
  logic [6:0] last_r;
  logic [9:0] loopCnt_r;
  logic [23:0] tickCnt_r;
  logic [2:0] istat_r;
  logic [2:0] mask_r;
  logic [47:0] slotData;

  logic busReq;
  logic wrEn;
  logic rdEn;
  logic [7:0] adrW;
  logic [31:0] rdMux;
  logic [31:0] wrWord;
  logic cmdGo;
  cmd_t cmdOp;
  logic [15:0] cmdVal;
  logic cmdErr;
  logic cmdOk;
  logic running;
  logic stepTick;
  logic passEnd;
  logic finish;
  logic [9:0] loopsInc;
  logic [2:0] events;

  // Reset release through two flops
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rstMeta_r <= 1'b0;
      rstSync_r <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstSync_r <= rstMeta_r;
    end
  end

  // Bus slave: one request taken per ack, so ack drops the cycle after
  assign busReq = cyc_i & stb_i & ~ack_r;
  assign wrEn = busReq & we_i;
  assign rdEn = busReq & ~we_i;
  assign adrW = {adr_i[7:2], 2'b00};
  assign ack_o = ack_r;
  assign dat_o = dat_r;

  always_ff @(posedge clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= busReq;
    end
  end

  always_comb begin
    rdMux = 32'h0000_0000;
    if (adrW == `REG_CMD) begin
      rdMux = cmdWord_r;
    end else if (adrW == `REG_SETV) begin
      rdMux = {16'h0000, setV_r};
    end else if (adrW == `REG_SETI) begin
      rdMux = {16'h0000, setI_r};
    end else if (adrW == `REG_SETP) begin
      rdMux = {16'h0000, setP_r};
    end else if (adrW == `REG_SLOT) begin
      rdMux = {30'h0000_0000, activeSlot_r};
    end else if (adrW == `REG_MODE) begin
      rdMux = {30'h0000_0000, mode_r};
    end else if (adrW == `REG_STEP) begin
      rdMux = {6'h00, loopsDone_r, 9'h000, step_r};
    end else if (adrW == `REG_FIRST) begin
      rdMux = {25'h000_0000, first_r};
    end else if (adrW == `REG_LAST) begin
      rdMux = {25'h000_0000, last_r};
    end else if (adrW == `REG_LOOPS) begin
      rdMux = {22'h00_0000, loopCnt_r};
    end else if (adrW == `REG_ISTAT) begin
      rdMux = {29'h0000_0000, istat_r};
    end else if (adrW == `REG_IMASK) begin
      rdMux = {29'h0000_0000, mask_r};
    end
  end

  // Old contents come from the read mux, so partial lanes keep their bits
  for (genvar g = 0; g < 4; g++) begin : gLane
    assign wrWord[8*g +: 8] = sel_i[g] ? dat_i[8*g +: 8] : rdMux[8*g +: 8];
  end

  always_ff @(posedge clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      dat_r <= 32'h0000_0000;
    end else if (rdEn) begin
      dat_r <= rdMux;
    end
  end

  // Command decode
  assign cmdGo = wrEn && (adrW == `REG_CMD);
  assign cmdOp = cmd_t'(wrWord[`CMD_OP_MSB:`CMD_OP_LSB]);
  assign cmdVal = wrWord[`CMD_VAL_MSB:`CMD_VAL_LSB];
  assign running = (mode_r == SEQ_RUN);

  always_comb begin
    cmdErr = 1'b0;
    case (cmdOp)
      CMD_RECALL: begin
        cmdErr = running || (cmdVal > `SLOT_MAX);
      end
      CMD_SAVE: begin
        cmdErr = running || (cmdVal == 16'h0000) || (cmdVal > `SLOT_MAX);
      end
      CMD_MODE: begin
        cmdErr = (cmdVal > `MODE_MAX);
      end
      CMD_JUMP: begin
        cmdErr = (mode_r != SEQ_PAUSE) || (cmdVal > `STEP_MAX);
      end
      CMD_FIRST: begin
        cmdErr = (cmdVal > `STEP_MAX);
      end
      CMD_LAST: begin
        cmdErr = (cmdVal > `STEP_MAX);
      end
      CMD_LOOPS: begin
        cmdErr = (cmdVal > `LOOP_MAX);
      end
      default: begin
        cmdErr = 1'b1;
      end
    endcase
  end

  assign cmdOk = cmdGo & ~cmdErr;

  always_ff @(posedge clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      cmdWord_r <= 32'h0000_0000;
    end else if (cmdGo) begin
      cmdWord_r <= wrWord;
    end
  end

  slot_store slots (
    .clk(clk),
    .wrEn(cmdOk && (cmdOp == CMD_SAVE)),
    .wrAddr(cmdVal[1:0]),
    .wrData({setP_r, setI_r, setV_r}),
    .rdAddr(cmdVal[1:0]),
    .rdData(slotData)
  );

  always_ff @(posedge clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      activeSlot_r <= 2'b00;
      loadPend_r <= 1'b0;
    end else begin
      loadPend_r <= cmdOk && (cmdOp == CMD_RECALL) && (cmdVal != 16'h0000);
      if (cmdOk && (cmdOp == CMD_RECALL)) begin
        activeSlot_r <= cmdVal[1:0];
      end
    end
  end

  // Slot data arrives a cycle late; no bus write can land in that cycle
  always_ff @(posedge clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      setV_r <= `SETV_RST;
      setI_r <= `SETI_RST;
      setP_r <= `SETP_RST;
    end else if (loadPend_r) begin
      setV_r <= slotData[15:0];
      setI_r <= slotData[31:16];
      setP_r <= slotData[47:32];
    end else if (wrEn && (adrW == `REG_SETV)) begin
      setV_r <= wrWord[15:0];
    end else if (wrEn && (adrW == `REG_SETI)) begin
      setI_r <= wrWord[15:0];
    end else if (wrEn && (adrW == `REG_SETP)) begin
      setP_r <= wrWord[15:0];
    end
  end

  always_ff @(posedge clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      first_r <= 7'h00;
      last_r <= 7'h00;
      loopCnt_r <= 10'h000;
    end else if (cmdOk) begin
      if (cmdOp == CMD_FIRST) begin
        first_r <= cmdVal[6:0];
      end
      if (cmdOp == CMD_LAST) begin
        last_r <= cmdVal[6:0];
      end
      if (cmdOp == CMD_LOOPS) begin
        loopCnt_r <= cmdVal[9:0];
      end
    end
  end

  // Step timer only runs in run mode, so a pause restarts the dwell from zero
  always_ff @(posedge clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      tickCnt_r <= 24'h00_0000;
    end else if (!running || stepTick) begin
      tickCnt_r <= 24'h00_0000;
    end else begin
      tickCnt_r <= tickCnt_r + 24'h00_0001;
    end
  end

  assign stepTick = running && (tickCnt_r == 24'(STEP_CYCLES - 1));
  assign passEnd = stepTick && (step_r == last_r);
  assign loopsInc = loopsDone_r + 10'h001;
  assign finish = passEnd && (loopCnt_r != 10'h000) &&
                  (loopsInc >= loopCnt_r);

  always_ff @(posedge clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      mode_r <= SEQ_STOP;
      step_r <= 7'h00;
      loopsDone_r <= 10'h000;
    end else if (cmdOk && (cmdOp == CMD_MODE)) begin
      mode_r <= seq_mode_t'(cmdVal[1:0]);
      if ((cmdVal[1:0] == 2'b10) && (mode_r == SEQ_STOP)) begin
        step_r <= first_r;
        loopsDone_r <= 10'h000;
      end
    end else if (cmdOk && (cmdOp == CMD_JUMP)) begin
      step_r <= cmdVal[6:0];
    end else if (passEnd) begin
      loopsDone_r <= loopsInc;
      if (finish) begin
        mode_r <= SEQ_STOP;
      end else begin
        step_r <= first_r;
      end
    end else if (stepTick) begin
      step_r <= (step_r == `STEP_LAST) ? 7'h00 : step_r + 7'h01;
    end
  end

  // Sticky events; a read clears, but an event in that cycle survives
  assign events = {passEnd, finish, cmdGo & cmdErr};

  always_ff @(posedge clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      istat_r <= 3'h0;
    end else if (rdEn && (adrW == `REG_ISTAT)) begin
      istat_r <= events;
    end else begin
      istat_r <= istat_r | events;
    end
  end

  always_ff @(posedge clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      mask_r <= `IMASK_RST;
    end else if (wrEn && (adrW == `REG_IMASK)) begin
      mask_r <= wrWord[2:0];
    end
  end

  assign irq = |(istat_r & mask_r);
  assign outVolt = setV_r;
  assign outCurr = setI_r;
  assign outPow = setP_r;
  assign seqStep = step_r;
  assign seqMode = mode_r;

  chk_busy_reject: assert property (
    @(posedge clk) disable iff (!rstSync_r)
    (cmdGo && running && (cmdOp == CMD_RECALL)) |=>
      ($stable(activeSlot_r) && istat_r[`IRQ_ERR]) ##1 $stable(setV_r))
    else $error("recall accepted while running");
  chk_recall_cancel: assert property (
    @(posedge clk) disable iff (!rstSync_r)
    (cmdOk && (cmdOp == CMD_RECALL) && (cmdVal == 16'h0000)) |=>
      (activeSlot_r == 2'b00) && !loadPend_r)
    else $error("recall 0 did not cancel slot");
  chk_save_range: assert property (
    @(posedge clk) disable iff (!rstSync_r)
    (cmdGo && (cmdOp == CMD_SAVE) && (cmdVal == 16'h0000)) |=>
      istat_r[`IRQ_ERR])
    else $error("save to slot 0 not flagged");

  chk_mode_run: assert property (@(posedge clk) disable iff (!rstSync_r)
    (cmdOk && (cmdOp == CMD_MODE) && (cmdVal == 16'h0002)) |=>
      (mode_r == SEQ_RUN))
    else $error("mode 2 did not run");

  chk_jump_step: assert property (@(posedge clk) disable iff (!rstSync_r)
    (cmdOk && (cmdOp == CMD_JUMP)) |=>
      (step_r == $past(cmdVal[6:0])) && (mode_r == SEQ_PAUSE))
    else $error("jump did not move step");
  chk_loop_endless: assert property (
    @(posedge clk) disable iff (!rstSync_r)
    (passEnd && (loopCnt_r == 10'h000) && !cmdGo) |=>
      (mode_r == SEQ_RUN) && (step_r == $past(first_r)))
    else $error("endless sequence stopped");

  chk_loop_stop: assert property (@(posedge clk) disable iff (!rstSync_r)
    (passEnd && (loopCnt_r != 10'h000) && (loopsInc == loopCnt_r)) |=>
      (mode_r == SEQ_STOP) && istat_r[`IRQ_DONE])
    else $error("sequence did not stop at loop count");
  chk_limits_held: assert property (
    @(posedge clk) disable iff (!rstSync_r)
    (first_r <= `STEP_LAST) && (last_r <= `STEP_LAST) &&
    ({6'h00, loopCnt_r} <= `LOOP_MAX))
    else $error("stored limit out of range");

  chk_loops_set: assert property (@(posedge clk) disable iff (!rstSync_r)
    (cmdOk && (cmdOp == CMD_LOOPS)) |=>
      (loopCnt_r == $past(cmdVal[9:0])))
    else $error("loop count not stored");

endmodule

// ### host_model.sv
`timescale 1ns/100ps
module host_model (
  input wire logic clk,
  input wire logic ack,
  input wire logic [31:0] rdat,
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [7:0] adr,
  output logic [3:0] sel,
  output logic [31:0] dat
);
  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    dat = 32'h0;
  end

  // One classic cycle; request held until ack is sampled high
  task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    dat <= d;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    // Released data must not look like the last value
    dat <= ~d;
  endtask
endmodule

// ### tb.sv
`timescale 1ns/100ps
`include "seq_ctrl_defs.svh"
module tb;
  import seq_ctrl_pkg::*;
  logic clk = 1'b0;
  logic arstN = 1'b0;
  logic cyc, stb, we, ack, irq;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] datW, datR, r;
  logic [15:0] outVolt, outCurr, outPow;
  logic [6:0] seqStep;
  seq_mode_t seqMode;
  int n_mismatch = 0;
  int samples_checked = 0;

  always #50 clk = ~clk;

  host_model u_host (.clk(clk), .ack(ack), .rdat(datR), .cyc(cyc),
    .stb(stb), .we(we), .adr(adr), .sel(sel), .dat(datW));

  setting_slot_and_sequence_control #(.STEP_CYCLES(4)) u_dut (
    .clk(clk), .arst_n(arstN), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(datW), .dat_o(datR), .ack_o(ack),
    .irq(irq), .outVolt(outVolt), .outCurr(outCurr), .outPow(outPow),
    .seqStep(seqStep), .seqMode(seqMode));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    u_host.xfer(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    u_host.xfer(1'b0, a, 32'h0, q);
  endtask

  task automatic cmd(input cmd_t op, input logic [15:0] v);
    wr(`REG_CMD, {12'h000, op, v});
  endtask

  // Reads status, which also clears it; only the error bit is judged
  task automatic errchk(input logic e);
    rd(`REG_ISTAT, r);
    chk({31'h0, r[0]}, {31'h0, e});
  endtask

  task automatic t_regs;
    rd(8'h3c, r);
    chk(r, 32'h0); // unmapped
    wr(`REG_IMASK, 32'h1);
    wr(`REG_CMD, 32'h0007_0000);
    chk({31'h0, irq}, 32'h1); // bad opcode
    errchk(1'b1);
    chk({31'h0, irq}, 32'h0);
    wr(`REG_IMASK, 32'h0);
  endtask

  task automatic t_slots;
    wr(`REG_SETV, 32'h1234);
    wr(`REG_SETI, 32'h0567);
    wr(`REG_SETP, 32'h0089);
    cmd(CMD_SAVE, 16'h2);
    wr(`REG_SETV, 32'h1111);
    cmd(CMD_RECALL, 16'h2);
    // Slot values land on the edge at which ack is seen
    @(posedge clk);
    chk({16'h0, outVolt}, 32'h1234);
    chk({16'h0, outCurr}, 32'h0567);
    chk({16'h0, outPow}, 32'h0089);
    rd(`REG_SLOT, r);
    chk(r, 32'h2);
    cmd(CMD_RECALL, 16'h0);
    rd(`REG_SLOT, r);
    chk(r, 32'h0);
    errchk(1'b0);
    cmd(CMD_SAVE, 16'h0);
    errchk(1'b1);
    cmd(CMD_SAVE, 16'h4);
    errchk(1'b1);
    cmd(CMD_RECALL, 16'h4);
    errchk(1'b1);
  endtask

  task automatic t_limits;
    cmd(CMD_FIRST, 16'd3);
    cmd(CMD_LAST, 16'd99);
    rd(`REG_LAST, r);
    chk(r, 32'd99);
    cmd(CMD_LAST, 16'd4);
    cmd(CMD_LOOPS, 16'd999);
    errchk(1'b0);
    cmd(CMD_LOOPS, 16'd1000);
    errchk(1'b1);
    rd(`REG_LOOPS, r);
    chk(r, 32'd999);
    cmd(CMD_FIRST, 16'd100);
    errchk(1'b1);
    wr(`REG_FIRST, 32'd9);
    rd(`REG_FIRST, r);
    chk(r, 32'd3);
    cmd(CMD_MODE, 16'd3);
    errchk(1'b1);
  endtask

  task automatic t_run;
    cmd_t ops[3];
    ops = '{CMD_RECALL, CMD_SAVE, CMD_JUMP};
    cmd(CMD_LOOPS, 16'd5);
    wr(`REG_IMASK, 32'h2);
    cmd(CMD_MODE, 16'd2);
    rd(`REG_MODE, r);
    chk(r, 32'd2);
    chk({30'h0, seqMode}, 32'd2);
    for (int k = 0; k < 3; k++) begin
      cmd(ops[k], 16'd1);
      errchk(1'b1);
    end
    for (int k = 0; k < 60 && r !== 32'h0; k++) begin
      rd(`REG_MODE, r);
    end
    chk(r, 32'h0);
    chk({31'h0, irq}, 32'h1);
    rd(`REG_STEP, r);
    chk({22'h0, r[25:16]}, 32'd5);
    rd(`REG_ISTAT, r);
    chk({31'h0, r[1]}, 32'h1);
    chk({31'h0, irq}, 32'h0);
  endtask

  task automatic t_pause;
    cmd(CMD_JUMP, 16'd7);
    errchk(1'b1);
    cmd(CMD_MODE, 16'd1);
    rd(`REG_MODE, r);
    chk(r, 32'd1);
    cmd(CMD_JUMP, 16'd99);
    chk({25'h0, seqStep}, 32'd99);
    cmd(CMD_JUMP, 16'd50);
    rd(`REG_STEP, r);
    chk({25'h0, r[6:0]}, 32'd50);
    cmd(CMD_JUMP, 16'd100);
    errchk(1'b1);
    chk({25'h0, seqStep}, 32'd50);
    cmd(CMD_MODE, 16'd0);
    rd(`REG_MODE, r);
    chk(r, 32'd0);
  endtask

  task automatic t_endless;
    cmd(CMD_LOOPS, 16'd0);
    cmd(CMD_MODE, 16'd2);
    repeat (80) @(posedge clk);
    rd(`REG_MODE, r);
    chk(r, 32'd2);
    rd(`REG_STEP, r);
    chk({31'h0, r[25:16] > 10'd3}, 32'h1);
    cmd(CMD_MODE, 16'd0);
    rd(`REG_MODE, r);
    chk(r, 32'd0);
    errchk(1'b0);
    chk({31'h0, r[2]}, 32'h1);
  endtask

  task automatic tally_and_finish;
    $display("Mismatches %0d, checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk);
    arstN <= 1'b1;
    repeat (4) @(posedge clk);
    t_regs();
    t_slots();
    t_limits();
    t_run();
    t_pause();
    t_endless();
    tally_and_finish();
  end

  // Whole run needs a few hundred cycles; this cuts a hang short
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    tally_and_finish();
  end
endmodule
